/* File: rtl/pnwe_pkg.sv */
`default_nettype none
package pnwe_pkg;
    // error tally range and overflow threshold
    localparam int unsigned TALLY_W   = 6;
    localparam logic [5:0]  TALLY_MAX = 6'h1F;
    localparam logic [5:0]  TALLY_ZERO = 6'h00;
    localparam logic [5:0]  TALLY_ONE  = 6'h01;
    // bus silence timeout
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned SILENCE_US    = 1000;
    localparam int unsigned SILENCE_CYC   = SILENCE_US * CLK_MHZ;
    localparam int unsigned SIL_W         = 20;
    // interrupt sources
    localparam int unsigned IRQ_N       = 8;
    localparam int unsigned IRQ_PO      = 0;
    localparam int unsigned IRQ_FDERR   = 1;
    localparam int unsigned IRQ_WAKE    = 2;
    localparam logic [7:0]  IRQ_ALWAYS  = 8'h03;
    localparam logic [7:0]  IRQ_WAKEPO  = 8'h07;
    localparam logic [7:0]  IRQ_RESET   = 8'h01;
    localparam logic [7:0]  IRQ_NONE    = 8'h00;
    // frame detector states
    typedef enum logic [1:0] {
        PNWE_IDLE = 2'b00,
        PNWE_RUN  = 2'b01,
        PNWE_DONE = 2'b11
    } pnwe_state_t;
endpackage : pnwe_pkg
`default_nettype wire

/* File: rtl/pnwe_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module pnwe_irq
    import pnwe_pkg::*;
(
    input  wire logic               mclk_in,
    input  wire logic               resetn_in,
    input  wire logic [IRQ_N-1:0]   event_in,
    input  wire logic [IRQ_N-1:0]   enable_in,
    input  wire logic [IRQ_N-1:0]   clear_in,
    input  wire logic               low_power_in,
    input  wire logic               scope_in,
    output logic      [IRQ_N-1:0]   status_out,
    output logic                    rxd_irq_n_out
);
    logic [IRQ_N-1:0] gated;
    logic [IRQ_N-1:0] status_nxt;
    logic [IRQ_N-1:0] scope_mask;
    logic             rxd_nxt;

    // R14: per-source gating
    // R15: always-on sources
    assign gated = event_in & (enable_in | IRQ_ALWAYS);

    genvar i;
    generate
        for (i = 0; i < IRQ_N; i++) begin : g_bit
            // R16: write one clears
            // R17: set beats clear
            assign status_nxt[i] = gated[i] | (status_out[i] & ~clear_in[i]);
        end
    endgenerate

    // R13: pin scope select
    assign scope_mask = scope_in ? {IRQ_N{1'b1}} : IRQ_WAKEPO;
    // R12: low-power signalling
    assign rxd_nxt = ~(low_power_in && |(status_nxt & scope_mask));

    // power-on flag comes up set after reset
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_out    <= IRQ_RESET;
            rxd_irq_n_out <= 1'b1;
        end else begin
            status_out    <= status_nxt;
            rxd_irq_n_out <= rxd_nxt;
        end
    end
endmodule : pnwe_irq
`default_nettype wire

/* File: rtl/pnwe_top.sv */
// Summary of operation
// R1: protocol error before acknowledge increments the fault tally.
// R2: error-free classical frame decrements the fault tally.
// R3: content between CRC delimiter and next start-of-frame is ignored.
// R4: tally above 31 sets frame-detect-error flag and wakes the device.
// R5: current tally value is readable by the host.
// R6: tally cleared on bus silence, disable, or invalid configuration.
// R7: status bit reports whether the last frame decoded successfully.
// R8: disabled or unconfigured selective wake falls back to pattern wake.
// R9: FD frames are never accepted as valid wake frames.
// R10: FD frame increments tally unless tolerance bit set.
// R11: extra bit-filter settings tolerate FD at 1 and 5 Mbit/s.
// R12: in Standby and Sleep the receive pin signals pending interrupts.
// R13: scope bit selects wake/power-on only or any interrupt; the narrow scope here also passes frame-detect-error.
// R14: each source gated by own enable; receive pin low on interrupt.
// R15: power-on and frame-detect-error interrupts have no enable.
// R16: host clears status bits by writing one.
// R17: simultaneous set and clear leaves the bit set.
// R18: any configuration change drops the configuration-valid bit.
// R19: tally holds at zero on error-free frame at zero.
`timescale 1ns/1ps
`default_nettype none
module pnwe_top
    import pnwe_pkg::*;
#(
    parameter int unsigned SILENCE_CYCLES = SILENCE_CYC
)
(
    input  wire logic                 mclk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 bus_activity_in,
    input  wire logic                 sof_in,
    input  wire logic                 crc_delim_in,
    input  wire logic                 proto_error_in,
    input  wire logic                 frame_ok_in,
    input  wire logic                 fd_frame_in,
    input  wire logic                 id_match_in,
    input  wire logic                 wup_detect_in,
    input  wire logic                 selective_wake_enable_in,
    input  wire logic                 cfg_write_in,
    input  wire logic                 cfg_valid_set_in,
    input  wire logic                 fd_frame_tolerate_in,
    input  wire logic                 fd_filter_ext_in,
    input  wire logic                 rx_pin_irq_scope_in,
    input  wire logic                 low_power_in,
    input  wire logic [IRQ_N-1:0]     irq_event_in,
    input  wire logic [IRQ_N-1:0]     irq_enable_in,
    input  wire logic [IRQ_N-1:0]     irq_clear_in,
    output logic [TALLY_W-1:0]        pn_fault_tally_out,
    output logic                      last_frame_decoded_ok_out,
    output logic                      pn_config_valid_out,
    output logic                      frame_detect_error_flag_out,
    output logic                      wake_out,
    output logic                      fd_filter_ext_out,
    output logic [IRQ_N-1:0]          irq_status_out,
    output logic                      rxd_irq_n_out
);
    pnwe_state_t         state_r;
    pnwe_state_t         state_nxt;
    logic [TALLY_W-1:0]  tally_r;
    logic [TALLY_W-1:0]  tally_nxt;
    logic [SIL_W-1:0]    sil_r;
    logic [SIL_W-1:0]    sil_nxt;
    logic                valid_r;
    logic                valid_nxt;
    logic                last_frame_decoded_ok_r;
    logic                last_frame_decoded_ok_nxt;
    logic                fderr_r;
    logic                wake_r;
    logic                filt_r;
    logic                in_frame;
    logic                pn_active;
    logic                silent;
    logic                err_ev;
    logic                ok_ev;
    logic                fd_err;
    logic                inc;
    logic                dec;
    logic                over;
    logic                wuf_hit;
    logic                wup_hit;
    logic [IRQ_N-1:0]    irq_ev;

    // R3: evaluation window
    assign in_frame  = (state_r == PNWE_RUN);
    assign pn_active = selective_wake_enable_in && valid_r;
    assign silent    = (sil_r >= SILENCE_CYCLES[SIL_W-1:0]);

    // R1: protocol error count
    assign err_ev = in_frame && proto_error_in;
    // R10: fd tolerance option
    assign fd_err = in_frame && crc_delim_in && fd_frame_in
                    && !fd_frame_tolerate_in && !proto_error_in;
    // R2: clean classical frame
    assign ok_ev  = in_frame && crc_delim_in && frame_ok_in
                    && !fd_frame_in && !proto_error_in;
    assign inc    = err_ev || fd_err;
    assign dec    = ok_ev && !inc;
    // R4: overflow above 31
    assign over   = inc && (tally_r == TALLY_MAX);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PNWE_IDLE: if (sof_in) state_nxt = PNWE_RUN;
            PNWE_RUN: begin
                if (proto_error_in || crc_delim_in) begin
                    state_nxt = PNWE_DONE;
                end
            end
            PNWE_DONE: if (sof_in) state_nxt = PNWE_RUN;
        endcase
        if (!pn_active) begin
            state_nxt = PNWE_IDLE;
        end
    end

    always_comb begin
        tally_nxt = tally_r;
        // R6: clear conditions
        if (!pn_active || silent) begin
            tally_nxt = TALLY_ZERO;
        end else if (inc && !over) begin
            tally_nxt = tally_r + TALLY_ONE;
        // R19: hold at zero
        end else if (dec && tally_r != TALLY_ZERO) begin
            tally_nxt = tally_r - TALLY_ONE;
        end
    end

    // silence counter saturates so it never wraps back to active
    assign sil_nxt = bus_activity_in ? '0 :
                     (silent ? sil_r : sil_r + 1'b1);

    // R18: config change drops valid
    assign valid_nxt = cfg_write_in ? 1'b0 :
                       (cfg_valid_set_in ? 1'b1 : valid_r);

    // R7: last frame status
    assign last_frame_decoded_ok_nxt = (in_frame && (proto_error_in || crc_delim_in)) ?
                      (ok_ev) : last_frame_decoded_ok_r;

    // R9: fd never a wake frame
    assign wuf_hit = ok_ev && id_match_in && !fd_frame_in;
    // R8: pattern wake fallback
    assign wup_hit = !pn_active && wup_detect_in;

    assign irq_ev = irq_event_in
                    | ({{(IRQ_N-1){1'b0}}, over} << IRQ_FDERR)
                    | ({{(IRQ_N-1){1'b0}}, wuf_hit | wup_hit} << IRQ_WAKE);

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= PNWE_IDLE;
            tally_r <= TALLY_ZERO;
            sil_r   <= '0;
            valid_r <= 1'b0;
            last_frame_decoded_ok_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tally_r <= tally_nxt;
            sil_r   <= sil_nxt;
            valid_r <= valid_nxt;
            last_frame_decoded_ok_r  <= last_frame_decoded_ok_nxt;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fderr_r <= 1'b0;
            wake_r  <= 1'b0;
            filt_r  <= 1'b0;
        end else begin
            // R4: flag and wake
            fderr_r <= over | (fderr_r & ~irq_clear_in[IRQ_FDERR]);
            wake_r  <= over | wuf_hit | wup_hit;
            // R11: extended bit filter
            filt_r  <= fd_filter_ext_in;
        end
    end

    // R5: tally readback
    assign pn_fault_tally_out          = tally_r;
    assign last_frame_decoded_ok_out   = last_frame_decoded_ok_r;
    assign pn_config_valid_out         = valid_r;
    assign frame_detect_error_flag_out = fderr_r;
    assign wake_out                    = wake_r;
    assign fd_filter_ext_out           = filt_r;

    // R14: interrupt gating
    pnwe_irq u_irq (
        .mclk_in       (mclk_in),
        .resetn_in     (resetn_in),
        .event_in      (irq_ev),
        .enable_in     (irq_enable_in),
        .clear_in      (irq_clear_in),
        .low_power_in  (low_power_in),
        .scope_in      (rx_pin_irq_scope_in),
        .status_out    (irq_status_out),
        .rxd_irq_n_out (rxd_irq_n_out)
    );
endmodule : pnwe_top
`default_nettype wire

/* File: dv/pnwe_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pnwe_bus_model (
    input  wire logic mclk_in,
    output var logic  sof_out,
    output var logic  crc_delim_out,
    output var logic  proto_error_out,
    output var logic  frame_ok_out,
    output var logic  fd_frame_out,
    output var logic  id_match_out
);
    // frame_ok_out, fd_frame_out and id_match_out idle at the inverse of the frame last driven, so stale values never help
    initial {sof_out, crc_delim_out, proto_error_out} = 3'h0;
    initial {frame_ok_out, fd_frame_out, id_match_out} = 3'h3;
    task automatic frame(input logic err, input logic ok, input logic fd,
                         input logic id);
        @(posedge mclk_in);
        sof_out <= 1'b1;
        @(posedge mclk_in);
        sof_out <= 1'b0;
        @(posedge mclk_in);
        proto_error_out <= err;
        crc_delim_out <= ~err;
        {frame_ok_out, fd_frame_out, id_match_out} <= {ok, fd, id};
        @(posedge mclk_in);
        {proto_error_out, crc_delim_out} <= 2'h0;
        {frame_ok_out, fd_frame_out, id_match_out} <= ~{ok, fd, id};
    endtask : frame
    task automatic stray();
        @(posedge mclk_in);
        proto_error_out <= 1'b1;
        @(posedge mclk_in);
        proto_error_out <= 1'b0;
    endtask : stray
endmodule : pnwe_bus_model
`default_nettype wire

/* File: dv/pnwe_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pnwe_top_chk
    import pnwe_pkg::*;
(
    input wire logic               mclk_in,
    input wire logic               resetn_in,
    input wire logic               bus_activity_in,
    input wire logic               sof_in,
    input wire logic               crc_delim_in,
    input wire logic               proto_error_in,
    input wire logic               frame_ok_in,
    input wire logic               fd_frame_in,
    input wire logic               selective_wake_enable_in,
    input wire logic               cfg_write_in,
    input wire logic               cfg_valid_set_in,
    input wire logic               fd_frame_tolerate_in,
    input wire logic               rx_pin_irq_scope_in,
    input wire logic               low_power_in,
    input wire logic [IRQ_N-1:0]   irq_event_in,
    input wire logic [IRQ_N-1:0]   irq_enable_in,
    input wire logic [IRQ_N-1:0]   irq_clear_in,
    input wire logic [TALLY_W-1:0] pn_fault_tally_out,
    input wire logic               pn_config_valid_out,
    input wire logic               frame_detect_error_flag_out,
    input wire logic               wake_out,
    input wire logic [IRQ_N-1:0]   irq_status_out,
    input wire logic               rxd_irq_n_out
);
    wire logic [TALLY_W-1:0] t = pn_fault_tally_out;
    wire logic v = selective_wake_enable_in && pn_config_valid_out
        && bus_activity_in && !cfg_write_in;
    wire logic any = low_power_in && rx_pin_irq_scope_in
        && irq_status_out != IRQ_NONE;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    chk_err_incr: assert property (sof_in && v ##2 proto_error_in && v
        && t < TALLY_MAX |=> t == $past(t) + TALLY_ONE) else $error("no inc");
    chk_ok_decr: assert property (sof_in && v ##2 crc_delim_in && v
        && frame_ok_in && !fd_frame_in |=> t == ($past(t) == TALLY_ZERO ?
        TALLY_ZERO : $past(t) - TALLY_ONE)) else $error("no dec");
    chk_fd_tally: assert property (sof_in && v ##2 crc_delim_in && v
        && fd_frame_in && t < TALLY_MAX |=> t == $past(t) +
        ($past(fd_frame_tolerate_in) ? TALLY_ZERO : TALLY_ONE))
        else $error("fd count wrong");
    chk_ovf_wake: assert property (sof_in && v ##2 proto_error_in && v
        && t == TALLY_MAX |=> frame_detect_error_flag_out && wake_out
        && irq_status_out[IRQ_FDERR]) else $error("no overflow wake");
    chk_tally_clear: assert property (!selective_wake_enable_in
        || !pn_config_valid_out |=> t == TALLY_ZERO) else $error("no clear");
    chk_cfg_drop: assert property (cfg_write_in && !cfg_valid_set_in
        |=> !pn_config_valid_out) else $error("valid kept");
    chk_set_wins: assert property (irq_event_in[3] && irq_enable_in[3]
        && irq_clear_in[3] |=> irq_status_out[3]) else $error("set lost");
    chk_w1c_clear: assert property (irq_clear_in[3] && !irq_event_in[3]
        |=> !irq_status_out[3]) else $error("bit not cleared");
    chk_rxd_any: assert property (any ##1 any |-> !rxd_irq_n_out)
        else $error("rxd not low");
    cover property (wake_out && frame_detect_error_flag_out);
    cover property (irq_event_in[3] && irq_clear_in[3]);
    cover property (low_power_in && !rxd_irq_n_out);
endmodule : pnwe_top_chk
bind pnwe_top pnwe_top_chk i_chk (.*);
`default_nettype wire

/* File: dv/pnwe_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pnwe_top_tb_top;
    import pnwe_pkg::*;
    logic       mclk_in = 1'b0, resetn_in = 1'b0, act = 1'b1, wup = 1'b0;
    logic       swe = 1'b1, cfgw = 1'b0, cfgv = 1'b0, tol = 1'b0;
    logic       fext = 1'b1, scope = 1'b0, lp = 1'b0, woke = 1'b0;
    logic       sof, crc, perr, fok, fdf, idm, last_frame_decoded_ok, vld, fde, wk, fxo, rxn;
    logic [7:0] ev = 8'h00, en = 8'h04, clr = 8'h00, st;
    logic [5:0] tly;
    int         n_mismatch = 0, cmp_count = 0;
    always #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (wk) woke <= 1'b1;
    pnwe_bus_model i_bus (.mclk_in(mclk_in), .sof_out(sof),
        .crc_delim_out(crc), .proto_error_out(perr), .frame_ok_out(fok),
        .fd_frame_out(fdf), .id_match_out(idm));
    pnwe_top #(.SILENCE_CYCLES(50)) i_dut (.mclk_in(mclk_in),
        .resetn_in(resetn_in), .bus_activity_in(act), .sof_in(sof),
        .crc_delim_in(crc), .proto_error_in(perr), .frame_ok_in(fok),
        .fd_frame_in(fdf), .id_match_in(idm), .wup_detect_in(wup),
        .selective_wake_enable_in(swe), .cfg_write_in(cfgw),
        .cfg_valid_set_in(cfgv), .fd_frame_tolerate_in(tol),
        .fd_filter_ext_in(fext), .rx_pin_irq_scope_in(scope),
        .low_power_in(lp), .irq_event_in(ev), .irq_enable_in(en),
        .irq_clear_in(clr), .pn_fault_tally_out(tly),
        .last_frame_decoded_ok_out(last_frame_decoded_ok), .pn_config_valid_out(vld),
        .frame_detect_error_flag_out(fde), .wake_out(wk),
        .fd_filter_ext_out(fxo), .irq_status_out(st), .rxd_irq_n_out(rxn));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // results land one cycle after the sampling edge, so wait two
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick
    task automatic irq(input logic [7:0] e, input logic [7:0] c);
        @(posedge mclk_in);
        {ev, clr} <= {e, c};
        @(posedge mclk_in);
        {ev, clr} <= 16'h0000;
        tick(1);
    endtask : irq
    task automatic t_count();
        @(posedge mclk_in);
        cfgv <= 1'b1;
        @(posedge mclk_in);
        cfgv <= 1'b0;
        i_bus.frame(1'b0, 1'b1, 1'b0, 1'b0);
        tick(2);
        chk({2'h0, tly}, 8'h00);
        chk({7'h00, last_frame_decoded_ok}, 8'h01);
        repeat (3) i_bus.frame(1'b1, 1'b0, 1'b0, 1'b0);
        i_bus.stray();
        tick(2);
        chk({2'h0, tly}, 8'h03);
        chk({7'h00, last_frame_decoded_ok}, 8'h00);
        i_bus.frame(1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge mclk_in);
        tol <= 1'b1;
        i_bus.frame(1'b0, 1'b1, 1'b1, 1'b1);
        tick(2);
        chk({2'h0, tly}, 8'h02);
        chk(st & 8'h04, 8'h00);
        tol <= 1'b0;
        i_bus.frame(1'b0, 1'b1, 1'b1, 1'b1);
        tick(2);
        chk({2'h0, tly}, 8'h03);
        // matching classical frame must wake, unlike the fd one above
        i_bus.frame(1'b0, 1'b1, 1'b0, 1'b1);
        tick(2);
        chk({st[2], woke, tly}, 8'hC2);
    endtask : t_count
    task automatic t_wake();
        woke <= 1'b0;
        repeat (31) i_bus.frame(1'b1, 1'b0, 1'b0, 1'b0);
        tick(2);
        chk({woke, fde, st[1], tly[4:0]}, 8'hFF);
        @(posedge mclk_in);
        act <= 1'b0;
        tick(60);
        chk({2'h0, tly}, 8'h00);
        act <= 1'b1;
        i_bus.frame(1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge mclk_in);
        {cfgw, woke} <= 2'b10;
        @(posedge mclk_in);
        cfgw <= 1'b0;
        tick(2);
        chk({6'h00, vld, tly[0]}, 8'h00);
        // valid again but selective wake off: pattern wake must still work
        {cfgv, swe} <= 2'b10;
        irq(8'h00, 8'h00);
        {wup, woke, cfgv} <= 3'b000;
        irq(8'h00, 8'h00);
        wup <= 1'b1;
        irq(8'h00, 8'h00);
        wup <= 1'b0;
        chk({6'h00, vld, woke}, 8'h03);
    endtask : t_wake
    task automatic t_irq();
        lp <= 1'b1;
        irq(8'h00, 8'hFF);
        chk({st[6:0], rxn}, 8'h01);
        irq(8'h08, 8'h00);
        chk(st, 8'h00);
        en <= 8'h0C;
        irq(8'h08, 8'h00);
        chk({st[6:0], rxn}, 8'h11);
        scope <= 1'b1;
        irq(8'h08, 8'h08);
        chk({st[6:0], rxn}, 8'h10);
        irq(8'h02, 8'h08);
        chk({st[6:0], rxn}, 8'h04);
        {lp, fext} <= 2'b00;
        tick(2);
        chk({6'h00, fxo, rxn}, 8'h01);
    endtask : t_irq
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        tick(2);
        chk({st[6:0], rxn}, 8'h03);
        chk({tly, fxo, vld}, 8'h02);
        t_count();
        t_wake();
        t_irq();
        complete_run();
    end
    initial begin
        #50000;
        n_mismatch++;
        complete_run();
    end
endmodule : pnwe_top_tb_top
`default_nettype wire
